// *** rtl/tgs_gain_sequencer.sv ***
// gain sequencer top: register bank, curve memory, gain engine, word length
`timescale 1ns/1ps
module tgs_gain_sequencer #(
   parameter int HOLD_MULT = tgs_pkg::HOLD_MULT_DEF,
   parameter int SAMPLE_DIV = tgs_pkg::SAMPLE_DIV_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // serial configuration pins
   input wire logic sclk_i,
   input wire logic sen_n_i,
   input wire logic sdata_i,
   output logic serial_data_out_o,
   // synchronisation pin
   input wire logic sync_i,
   // converter data
   input wire logic [11:0] adc_sample_i,
   output logic [15:0] ser_word_o,
   output logic [4:0] bits_per_frame_o,
   // gain result, eighths of a decibel above minus five
   output logic [8:0] gain_code_o,
   output logic sample_en_o
);
   typedef struct packed {
      logic [15:0] ctrl0;
      logic [15:0] fmt;
      logic [15:0] amp;
      logic [7:0] first_ptr;
      logic [7:0] last_ptr;
      logic [7:0] init_gain;
      logic [7:0] hold_code;
      logic [7:0] mode;
      logic [7:0] coarse;
      logic [7:0] slope;
      tgs_pkg::tgs_state_t st;
      logic [7:0] ptr;
      logic [2:0] sub;
      logic [7:0] tick;
      logic [13:0] hold_cnt;
      logic [8:0] gain;
      logic [3:0] div;
      logic sample_en;
      logic sync_s1;
      logic sync_s2;
      logic sync_prev;
      logic [15:0] word;
      logic [4:0] frame_bits;
   } tgs_core_t;

   tgs_core_t q, d;
   logic [tgs_pkg::CURVE_WIDTH-1:0] curve_mem [0:tgs_pkg::CURVE_DEPTH-1];
   logic [7:0] port_addr;
   logic [15:0] port_wdata, rd_data;
   logic port_wr, wr_acc, bank, fine_en, sync_rise, do_step, stopping;
   logic [8:0] entry, start_gain, fixed_gain, step_sz, back_dist;
   logic [7:0] t_len;
   logic [13:0] hold_limit;

   // ***************************************
   // decode helpers
   // ***************************************
   function automatic logic is_curve(input logic [7:0] a);
      is_curve = (a >= tgs_pkg::ADDR_CURVE_FIRST) && (a <= tgs_pkg::ADDR_CURVE_LAST);
   endfunction

   function automatic logic [5:0] clamp_code(input logic [7:0] c);
      clamp_code = (c[5:0] > tgs_pkg::COARSE_MAX) ? tgs_pkg::COARSE_MAX : c[5:0];
   endfunction

   function automatic logic [7:0] min_len(input logic [7:0] t);
      min_len = (t < 8'h02) ? 8'h01 : t;
   endfunction

   function automatic logic [4:0] word_bits(input logic [1:0] code);
      case (code)
         2'b01: word_bits = 5'd10;
         2'b10: word_bits = 5'd16;
         2'b11: word_bits = 5'd14;
         default: word_bits = 5'd12;
      endcase
   endfunction

   // ***************************************
   // serial port
   // ***************************************
   tgs_serial_port u_port (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .sclk_i(sclk_i),
      .sen_n_i(sen_n_i),
      .sdata_i(sdata_i),
      .serial_data_out_o(serial_data_out_o),
      .readback_i(q.ctrl0[tgs_pkg::READBACK_BIT]),
      .rd_data_i(rd_data),
      .addr_o(port_addr),
      .wr_data_o(port_wdata),
      .wr_o(port_wr)
   );

   // readback multiplexer over both banks
   always_comb begin
      rd_data = 16'h0000;
      if (port_addr == tgs_pkg::ADDR_CONTROL_ZERO) begin
         rd_data = q.ctrl0;
      end else if (!bank) begin
         case (port_addr)
            tgs_pkg::ADDR_OUTPUT_FORMAT: rd_data = q.fmt;
            tgs_pkg::ADDR_AMPLIFIER: rd_data = q.amp;
            default: rd_data = 16'h0000;
         endcase
      end else if (is_curve(port_addr)) begin
         rd_data = {7'h00, curve_mem[8'(port_addr - 8'h01)]};
      end else begin
         case (port_addr)
            tgs_pkg::ADDR_FIRST_POINTER: rd_data = {8'h00, q.first_ptr};
            tgs_pkg::ADDR_LAST_POINTER: rd_data = {8'h00, q.last_ptr};
            tgs_pkg::ADDR_INITIAL_GAIN: rd_data = {8'h00, q.init_gain ^ 8'h80};
            tgs_pkg::ADDR_HOLD: rd_data = {8'h00, q.hold_code};
            tgs_pkg::ADDR_ENGINE_MODE: rd_data = {8'h00, q.mode};
            tgs_pkg::ADDR_COARSE_GAIN: rd_data = {8'h00, q.coarse};
            tgs_pkg::ADDR_RAMP_SLOPE: rd_data = {8'h00, q.slope};
            default: rd_data = 16'h0000;
         endcase
      end
   end

   // curve memory, written only with the curve bank selected
   always_ff @(posedge clk_i) begin
      if (wr_acc && bank && is_curve(port_addr)) begin
         curve_mem[8'(port_addr - 8'h01)] <= port_wdata[8:0];
      end
   end

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      d = q;
      bank = q.ctrl0[tgs_pkg::BANK_BIT];
      fine_en = q.init_gain[tgs_pkg::FINE_STEP_BIT];
      // readback mode lets only address zero through
      wr_acc = port_wr && (!q.ctrl0[tgs_pkg::READBACK_BIT] ||
                           port_addr == tgs_pkg::ADDR_CONTROL_ZERO);
      entry = is_curve(q.ptr) ? curve_mem[8'(q.ptr - 8'h01)] : 9'h000;
      start_gain = {clamp_code(q.init_gain), 3'b000};
      fixed_gain = {clamp_code(q.coarse), q.mode[2:0]};
      hold_limit = 14'(32'(q.hold_code) * HOLD_MULT);
      t_len = q.mode[tgs_pkg::UNIFORM_BIT] ? min_len(q.slope) : min_len(entry[7:0]);
      back_dist = (q.gain > start_gain) ? (q.gain - start_gain) : (start_gain - q.gain);
      sync_rise = q.sample_en && q.sync_s2 && !q.sync_prev;
      do_step = 1'b0;
      stopping = 1'b0;
      step_sz = fine_en ? tgs_pkg::FINE_STEP : tgs_pkg::COARSE_STEP;
      // register writes
      if (wr_acc) begin
         if (port_addr == tgs_pkg::ADDR_CONTROL_ZERO) begin
            d.ctrl0 = port_wdata;
         end else if (!bank) begin
            case (port_addr)
               tgs_pkg::ADDR_OUTPUT_FORMAT: d.fmt = port_wdata;
               tgs_pkg::ADDR_AMPLIFIER: d.amp = port_wdata;
               default: d.amp = q.amp;
            endcase
         end else begin
            case (port_addr)
               tgs_pkg::ADDR_FIRST_POINTER: d.first_ptr = port_wdata[7:0];
               tgs_pkg::ADDR_LAST_POINTER: d.last_ptr = port_wdata[7:0];
               tgs_pkg::ADDR_INITIAL_GAIN: d.init_gain = port_wdata[7:0] & tgs_pkg::INITIAL_GAIN_MASK;
               tgs_pkg::ADDR_HOLD: d.hold_code = port_wdata[7:0];
               tgs_pkg::ADDR_ENGINE_MODE: d.mode = port_wdata[7:0] & tgs_pkg::SIX_BIT_MASK;
               tgs_pkg::ADDR_COARSE_GAIN: d.coarse = port_wdata[7:0] & tgs_pkg::SIX_BIT_MASK;
               tgs_pkg::ADDR_RAMP_SLOPE: d.slope = port_wdata[7:0];
               default: d.slope = q.slope;
            endcase
         end
      end
      // sampling clock enable divider
      d.sample_en = 1'b0;
      if (q.div == 4'(SAMPLE_DIV - 1)) begin
         d.div = 4'h0;
         d.sample_en = 1'b1;
      end else begin
         d.div = q.div + 4'h1;
      end
      // sync pin synchroniser, sampled on the sampling edge
      d.sync_s1 = sync_i;
      d.sync_s2 = q.sync_s1;
      if (q.sample_en) begin
         d.sync_prev = q.sync_s2;
         d.word = {adc_sample_i, {(16 - tgs_pkg::ADC_BITS){1'b0}}};
      end
      d.frame_bits = word_bits(q.fmt[tgs_pkg::WORD_LEN_LSB +: 2]);
      if (q.st != tgs_pkg::TGS_HOLD) begin
         d.hold_cnt = 14'h0000;
      end
      // gain engine
      if (q.mode[tgs_pkg::FIXED_GAIN_BIT]) begin
         d.st = tgs_pkg::TGS_IDLE;
         d.gain = fixed_gain;
      end else if (q.sample_en) begin
         if (sync_rise || (q.st == tgs_pkg::TGS_IDLE && q.mode[tgs_pkg::SOFT_SYNC_BIT])) begin
            d.st = tgs_pkg::TGS_RAMP;
            d.gain = start_gain;
            d.ptr = q.first_ptr;
            d.sub = 3'h0;
            d.tick = 8'h00;
         end else begin
            case (q.st)
               tgs_pkg::TGS_RAMP: begin
                  d.tick = q.tick + 8'h01;
                  if (d.tick == t_len) begin
                     d.tick = 8'h00;
                     if (q.mode[tgs_pkg::UNIFORM_BIT]) begin
                        do_step = 1'b1;
                        step_sz = tgs_pkg::FINE_STEP;
                     end else if (q.sub != tgs_pkg::LAST_SUB) begin
                        d.sub = q.sub + 3'h1;
                        do_step = fine_en;
                     end else if (q.ptr == q.last_ptr ||
                                  q.ptr == 8'(tgs_pkg::CURVE_DEPTH)) begin
                        d.st = tgs_pkg::TGS_HOLD;
                     end else begin
                        d.sub = 3'h0;
                        d.ptr = q.ptr + 8'h01;
                        do_step = 1'b1;
                     end
                  end
                  if (do_step) begin
                     if (entry[8] && !q.mode[tgs_pkg::UNIFORM_BIT]) begin
                        stopping = q.gain < step_sz;
                        d.gain = stopping ? 9'h000 : q.gain - step_sz;
                     end else begin
                        stopping = (q.gain + step_sz) > tgs_pkg::GAIN_MAX;
                        d.gain = stopping ? tgs_pkg::GAIN_MAX : q.gain + step_sz;
                     end
                     if (stopping) begin
                        d.st = tgs_pkg::TGS_HOLD;
                     end
                  end
               end
               tgs_pkg::TGS_HOLD: begin
                  if (q.hold_cnt >= hold_limit) begin
                     d.st = tgs_pkg::TGS_BACK;
                  end else begin
                     d.hold_cnt = q.hold_cnt + 14'h0001;
                  end
               end
               tgs_pkg::TGS_BACK: begin
                  if (back_dist == 9'h000) begin
                     d.st = tgs_pkg::TGS_IDLE;
                  end else if (back_dist <= tgs_pkg::COARSE_STEP) begin
                     d.gain = start_gain;
                  end else if (q.gain > start_gain) begin
                     d.gain = q.gain - tgs_pkg::COARSE_STEP;
                  end else begin
                     d.gain = q.gain + tgs_pkg::COARSE_STEP;
                  end
               end
               default: d.st = tgs_pkg::TGS_IDLE;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
         q.st <= tgs_pkg::TGS_IDLE;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign gain_code_o = q.gain;
   assign ser_word_o = q.word;
   assign bits_per_frame_o = q.frame_bits;
   assign sample_en_o = q.sample_en;

   // ***************************************
   // checks
   // ***************************************
   chk_interp_inverted: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (bank && port_addr == tgs_pkg::ADDR_INITIAL_GAIN) |-> rd_data[7] != q.init_gain[7])
      else $error("interpolation bit not inverted on readback");
   chk_ctrl_zero_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (port_wr && port_addr == tgs_pkg::ADDR_CONTROL_ZERO) |=> q.ctrl0 == $past(port_wdata))
      else $error("address zero write lost");
   chk_readback_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (port_wr && q.ctrl0[1] && port_addr != 8'h00) |=> $stable(q.fmt) && $stable(q.first_ptr))
      else $error("write taken during readback");
   chk_hold_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (q.st == tgs_pkg::TGS_HOLD && hold_limit == 14'h0000 && q.sample_en && !sync_rise &&
       !q.mode[3]) |=> q.st == tgs_pkg::TGS_BACK)
      else $error("zero hold code still holds");
   chk_back_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (q.st == tgs_pkg::TGS_BACK && q.sample_en && !sync_rise && !q.mode[3] &&
       q.gain > start_gain + 9'h008) |=> q.gain == $past(q.gain) - 9'h008)
      else $error("return step not one decibel");
   chk_fixed_gain: assert property (@(posedge clk_i) disable iff (!nrst_i)
      q.mode[3] |=> gain_code_o == $past(fixed_gain) && q.st == tgs_pkg::TGS_IDLE)
      else $error("fixed gain mode not applied");
   chk_gain_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !q.mode[3] |-> gain_code_o <= tgs_pkg::GAIN_MAX)
      else $error("gain above limit");
   chk_sample_rate: assert property (@(posedge clk_i) disable iff (!nrst_i)
      q.sample_en |=> !q.sample_en)
      else $error("sampling enable too fast");
   chk_word_pad: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ser_word_o[3:0] == 4'h0)
      else $error("padding bits not zero");
   chk_sync_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (sync_rise && !q.mode[3]) |=> q.st == tgs_pkg::TGS_RAMP && q.gain == $past(start_gain)
      && q.ptr == $past(q.first_ptr))
      else $error("sync did not start curve");
endmodule

// *** rtl/tgs_pkg.sv ***
// constants, encodings and state type for the gain sequencer and its register bank
package tgs_pkg;
   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] ADDR_CURVE_FIRST = 8'h01;
   localparam logic [7:0] ADDR_CURVE_LAST = 8'h94;
   localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h03;
   localparam logic [7:0] ADDR_AMPLIFIER = 8'h07;
   localparam logic [7:0] ADDR_FIRST_POINTER = 8'h95;
   localparam logic [7:0] ADDR_LAST_POINTER = 8'h96;
   localparam logic [7:0] ADDR_INITIAL_GAIN = 8'h97;
   localparam logic [7:0] ADDR_HOLD = 8'h98;
   localparam logic [7:0] ADDR_ENGINE_MODE = 8'h99;
   localparam logic [7:0] ADDR_COARSE_GAIN = 8'h9A;
   localparam logic [7:0] ADDR_RAMP_SLOPE = 8'h9B;
   localparam int CURVE_DEPTH = 148;
   localparam int CURVE_WIDTH = 9;
   // ***************************************
   // field positions, masks and reset values
   // ***************************************
   localparam int READBACK_BIT = 1;
   localparam int BANK_BIT = 2;
   localparam int WORD_LEN_LSB = 13;
   localparam int FINE_STEP_BIT = 7;
   localparam int SOFT_SYNC_BIT = 5;
   localparam int UNIFORM_BIT = 4;
   localparam int FIXED_GAIN_BIT = 3;
   localparam logic [7:0] INITIAL_GAIN_MASK = 8'hBF;
   localparam logic [7:0] SIX_BIT_MASK = 8'h3F;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ***************************************
   // gain arithmetic and timing
   // ***************************************
   localparam logic [5:0] COARSE_MAX = 6'h24;
   localparam logic [8:0] GAIN_MAX = 9'h120;
   localparam logic [8:0] FINE_STEP = 9'h001;
   localparam logic [8:0] COARSE_STEP = 9'h008;
   localparam logic [2:0] LAST_SUB = 3'h7;
   localparam int HOLD_MULT_DEF = 33;
   localparam int SAMPLE_DIV_DEF = 2;
   localparam int ADC_BITS = 12;
   localparam int SERIAL_FRAME_BITS = 24;
   localparam int SERIAL_ADDR_BITS = 8;
   // ***************************************
   // engine states
   // ***************************************
   typedef enum logic [3:0] {
      TGS_IDLE = 4'b0001,
      TGS_RAMP = 4'b0010,
      TGS_HOLD = 4'b0100,
      TGS_BACK = 4'b1000
   } tgs_state_t;
endpackage

// *** rtl/tgs_serial_port.sv ***
// serial configuration port: pin synchronisers, shifter and readback driver
`timescale 1ns/1ps
module tgs_serial_port (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // serial pins
   input wire logic sclk_i,
   input wire logic sen_n_i,
   input wire logic sdata_i,
   output logic serial_data_out_o,
   // register side
   input wire logic readback_i,
   input wire logic [15:0] rd_data_i,
   output logic [7:0] addr_o,
   output logic [15:0] wr_data_o,
   output logic wr_o
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic sclk_prev;
      logic sen_prev;
      logic [4:0] cnt;
      logic [23:0] shreg;
      logic [15:0] rdsh;
      logic load;
      logic sdo;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } tgs_sp_t;

   tgs_sp_t q, d;
   logic sclk_s, sen_s, sdata_s, rise, fall;

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      d = q;
      sclk_s = q.s2[2];
      sen_s = q.s2[1];
      sdata_s = q.s2[0];
      rise = sclk_s & ~q.sclk_prev & ~sen_s;
      fall = ~sclk_s & q.sclk_prev & ~sen_s;
      d.s1 = {sclk_i, sen_n_i, sdata_i};
      d.s2 = q.s1;
      d.sclk_prev = sclk_s;
      d.sen_prev = sen_s;
      d.wr = 1'b0;
      d.load = 1'b0;
      if (rise && q.cnt != 5'(tgs_pkg::SERIAL_FRAME_BITS)) begin
         d.shreg = {q.shreg[22:0], sdata_s};
         d.cnt = q.cnt + 5'h01;
         if (q.cnt == 5'(tgs_pkg::SERIAL_ADDR_BITS - 1)) begin
            d.addr = {q.shreg[6:0], sdata_s};
            d.load = readback_i;
         end
      end
      // readback word loads once the address is known
      if (q.load) begin
         d.sdo = rd_data_i[15];
         d.rdsh = {rd_data_i[14:0], 1'b0};
      end
      // next bit changes on the fall so the controller samples on the rise
      if (fall && readback_i && q.cnt > 5'(tgs_pkg::SERIAL_ADDR_BITS)) begin
         d.sdo = q.rdsh[15];
         d.rdsh = {q.rdsh[14:0], 1'b0};
      end
      // frame ends when the enable returns high
      if (sen_s) begin
         d.cnt = 5'h00;
         d.sdo = 1'b0;
         if (!q.sen_prev && q.cnt == 5'(tgs_pkg::SERIAL_FRAME_BITS)) begin
            d.wr = 1'b1;
            d.wdata = q.shreg[15:0];
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
         // enable synchroniser starts at its idle high level, no false frame edge
         q.s1 <= 3'b010;
         q.s2 <= 3'b010;
         q.sen_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign serial_data_out_o = q.sdo;
   assign addr_o = q.addr;
   assign wr_data_o = q.wdata;
   assign wr_o = q.wr;

   chk_rb_first_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
      q.load |=> serial_data_out_o == $past(rd_data_i[15]))
      else $error("readback first bit not driven");
endmodule

// *** testbench/tb_top.sv ***
// testbench: register bank, word length, curve engine and fixed gain
`timescale 1ns/1ps
module tb_top;
   // ***************************************
   // clock, reset and wiring
   // ***************************************
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sclk, sen_n, sdata, sdo;
   logic sync_i = 1'b0;
   logic [11:0] adc = 12'h000;
   logic [15:0] ser_word, rd, w;
   logic [15:0] seed = 16'h003D;
   logic [4:0] bpf;
   logic smp_en, smp_prev;
   logic [8:0] gain;
   logic [5:0] g;
   logic [1:0] codes [3] = '{2'b00, 2'b10, 2'b11};
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   // 125 MHz clock
   always #4 clk_i = ~clk_i;
   tgs_gain_sequencer #(.HOLD_MULT(2), .SAMPLE_DIV(2)) u_tgs_gain_sequencer (
      .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .sen_n_i(sen_n), .sdata_i(sdata),
      .serial_data_out_o(sdo), .sync_i(sync_i), .adc_sample_i(adc),
      .ser_word_o(ser_word), .bits_per_frame_o(bpf), .gain_code_o(gain), .sample_en_o(smp_en));
   tgs_ctrl_model u_tgs_ctrl_model (
      .clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .sen_n_o(sen_n), .sdata_o(sdata));
   // ***************************************
   // helpers
   // ***************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [4:0] frame_bits(input logic [1:0] c);
      return (c == 2'b00) ? 5'h0C : (c == 2'b10) ? 5'h10 : 5'h0E;
   endfunction
   function automatic logic [8:0] fixed_gain(input logic [5:0] c, input logic [2:0] f);
      return {(c > 6'h24) ? 6'h24 : c, f};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_tgs_ctrl_model.xfer(a, d, rd);
   endtask
   // readback of one register, then readback switched off again
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input logic bk);
      wr(8'h00, {13'h0000, bk, 2'b10});
      wr(a, 16'hFFFF);
      check(rd, exp);
      wr(8'h00, {13'h0000, bk, 2'b00});
   endtask
   // sync pulse, track peak gain until back at start gain
   task automatic run_curve(input logic ip);
      logic [8:0] top;
      int n;
      int still;
      seed = lfsr(seed);
      g = seed[5:0] & 6'h1F;
      wr(8'h97, {8'h00, ip, 1'b0, g});
      sync_i = 1'b1;
      cyc(4);
      sync_i = 1'b0;
      cyc(4);
      top = {g, 3'h0};
      n = 0;
      still = 0;
      // done only when quiet at the start gain, a mid-curve dip is not the end
      while (n < 3000 && !(top > {g, 3'h0} && still >= 100)) begin
         if (gain > top) top = gain;
         still = (gain === {g, 3'h0}) ? still + 1 : 0;
         cyc(1);
         n++;
      end
      check({7'h00, top}, {7'h00, g + 6'h01, ip ? 3'h7 : 3'h0});
      check({7'h00, gain}, {7'h00, g, 3'h0});
      $display("test curve done");
   endtask
   // uniform ramp restarted by soft sync alone: reaches the ceiling twice
   task automatic run_uniform();
      int n;
      int peaks;
      n = 0;
      peaks = 0;
      wr(8'h9B, 16'h0002);
      wr(8'h99, 16'h0030);
      while (n < 6000 && peaks < 2) begin
         if (gain === 9'h120) begin
            peaks++;
            while (n < 6000 && gain !== {g, 3'h0}) begin
               cyc(1);
               n++;
            end
         end
         cyc(1);
         n++;
      end
      check(16'(peaks), 16'h0002);
      $display("test uniform done");
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      repeat (5) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      cyc(4);
      smp_prev = smp_en;
      cyc(1);
      check({15'h0000, smp_en}, {15'h0000, ~smp_prev});
      seed = lfsr(seed);
      w = seed;
      wr(8'h03, w);
      wr(8'h00, 16'h0004);
      wr(8'h03, ~w);
      wr(8'h97, 16'h00C5);
      rdchk(8'h03, {7'h00, ~w[8:0]}, 1'b1);
      rdchk(8'h97, 16'h0005, 1'b1);
      rdchk(8'h03, w, 1'b0);
      rdchk(8'hF0, 16'h0000, 1'b0);
      wr(8'h00, 16'h0002);
      wr(8'h07, w);
      wr(8'h07, 16'h0000);
      check(rd, 16'h0000);
      wr(8'h00, 16'h0000);
      wr(8'h07, w);
      rdchk(8'h07, w, 1'b0);
      $display("test registers done");
      // only word lengths not shorter than the converter
      foreach (codes[i]) begin
         seed = lfsr(seed);
         adc = seed[11:0];
         wr(8'h03, {1'b0, codes[i], 13'h0000});
         check({11'h000, bpf}, {11'h000, frame_bits(codes[i])});
         check(ser_word, {adc, 4'h0});
      end
      $display("test word length done");
      wr(8'h00, 16'h0004);
      wr(8'h95, 16'h0002);
      wr(8'h96, 16'h0005);
      wr(8'h98, 16'h0001);
      wr(8'h99, 16'h0000);
      for (int e = 2; e < 6; e++) begin
         seed = lfsr(seed);
         wr(e[7:0], {7'h00, e == 3, 6'h00, seed[1:0]});
      end
      run_curve(1'b0);
      wr(8'h98, 16'h0000);
      run_curve(1'b1);
      run_uniform();
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         if (k == 0) seed[5:0] = 6'h3F;
         wr(8'h9A, {10'h000, seed[5:0]});
         wr(8'h99, {12'h000, 1'b1, seed[8:6]});
         check({7'h00, gain}, {7'h00, fixed_gain(seed[5:0], seed[8:6])});
      end
      $display("test fixed gain done");
      report_and_stop();
   end
endmodule

// *** testbench/tgs_ctrl_model.sv ***
// external controller model driving the serial configuration pins
`timescale 1ns/1ps
module tgs_ctrl_model (
   // clock
   input wire logic clk_i,
   // serial pins
   input wire logic sdo_i,
   output logic sclk_o,
   output logic sen_n_o,
   output logic sdata_o
);
   // ***************************************
   // frame driver
   // ***************************************
   // idle pins: clock parked low, enable high
   initial begin
      sclk_o = 1'b0;
      sen_n_o = 1'b1;
      sdata_o = 1'b0;
   end
   // n clock edges, then a small step off the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // 24-bit frame, address then data, msb first; rd holds returned word
   task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] rd);
      logic [23:0] frame;
      frame = {a, d};
      rd = 16'h0000;
      sen_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata_o = frame[i];
         wait_clk(4);
         sclk_o = 1'b1;
         if (i < 16) rd[i] = sdo_i;
         wait_clk(4);
         sclk_o = 1'b0;
      end
      sen_n_o = 1'b1;
      sdata_o = ~sdata_o; // inverted line, no stale level
      wait_clk(8);
   endtask
endmodule
